// >>> lsdec_pkg.sv
// shared types and constants for the logic and string instruction decoder
package lsdec_pkg;
  // opcode patterns, compared against the upper bits of the first byte
  localparam logic [5:0] OPC_AND_RM   = 6'h08;  // 001000dw
  localparam logic [5:0] OPC_OR_RM    = 6'h02;  // 000010dw
  localparam logic [5:0] OPC_XOR_RM   = 6'h0C;  // 001100dw
  localparam logic [5:0] OPC_GRP_IMM  = 6'h20;  // 100000sw
  localparam logic [6:0] OPC_TEST_RM  = 7'h42;  // 1000010w
  localparam logic [6:0] OPC_GRP_UNA  = 7'h7B;  // 1111011w
  localparam logic [6:0] OPC_AND_ACC  = 7'h12;  // 0010010w
  localparam logic [6:0] OPC_OR_ACC   = 7'h06;  // 0000110w
  localparam logic [6:0] OPC_XOR_ACC  = 7'h1A;  // 0011010w
  localparam logic [6:0] OPC_TEST_ACC = 7'h54;  // 1010100w
  localparam logic [6:0] OPC_COMP     = 7'h53;  // 1010011w
  localparam logic [6:0] OPC_PIN      = 7'h36;  // 0110110w
  localparam logic [6:0] OPC_LOAD     = 7'h56;  // 1010110w
  localparam logic [6:0] OPC_MOVE     = 7'h52;  // 1010010w
  localparam logic [6:0] OPC_POUT     = 7'h37;  // 0110111w
  localparam logic [6:0] OPC_SCAN     = 7'h57;  // 1010111w
  localparam logic [6:0] OPC_STOR     = 7'h55;  // 1010101w
  localparam logic [7:0] PFX_REPEAT   = 8'hF3;  // repeat_while_equal_prefix
  // operation field of the addressing byte in the group forms
  localparam logic [2:0] FLD_AND  = 3'h4;
  localparam logic [2:0] FLD_OR   = 3'h1;
  localparam logic [2:0] FLD_XOR  = 3'h6;
  localparam logic [2:0] FLD_TEST = 3'h0;
  localparam logic [2:0] FLD_NOT  = 3'h2;
  localparam logic [1:0] MOD_REG  = 2'h3;   // mode value naming a register
  // execution clock counts
  localparam int CLK_W        = 5;
  localparam int REG_CLOCKS   = 2;
  localparam int MEM_RD_CLK   = 6;
  localparam int MEM_RMW_CLK  = 7;
  localparam int TEST_MEM_CLK = 5;
  localparam int NOT_MEM_CLK  = 6;
  localparam int COMP_CLK     = 10;
  localparam int PIN_CLK      = 9;
  localparam int LOAD_CLK     = 5;
  localparam int MOVE_CLK     = 7;
  localparam int POUT_CLK     = 8;
  localparam int STOR_CLK     = 4;
  // repeated forms: setup clocks and clocks per iteration
  localparam int R_COMP_SET = 5;
  localparam int R_COMP_IT  = 9;
  localparam int R_PIN_SET  = 7;
  localparam int R_PIN_IT   = 6;
  localparam int R_LOAD_SET = 5;
  localparam int R_LOAD_IT  = 6;
  localparam int R_MOVE_SET = 7;
  localparam int R_MOVE_IT  = 4;
  localparam int R_POUT_SET = 6;
  localparam int R_POUT_IT  = 5;
  localparam int R_SCAN_SET = 5;
  localparam int R_SCAN_IT  = 8;
  localparam int R_STOR_SET = 5;
  localparam int R_STOR_IT  = 5;

  // decoded operation
  typedef enum logic [3:0] {
    op_and, op_or, op_xor, op_test, op_not,
    compare_string, port_input_string, load_string, move_string,
    port_output_string, scan_string, store_string
  } op_t;

  // decoded instruction handed to the datapath
  typedef struct packed {
    op_t         op;
    logic        is_byte;     // width bit clear
    logic        reg_dest;    // register field names the destination
    logic        acc_form;    // short form on the accumulator
    logic        mem_operand; // operand in memory
    logic        repeated;    // repeat prefix seen
    logic [1:0]  mod_field;
    logic [2:0]  reg_field;
    logic [2:0]  rm_field;
    logic [31:0] imm;
  } exec_t;

  // timing of one operation
  typedef struct packed {
    logic [4:0] clocks;   // clocks of a single run or one iteration
    logic [4:0] setup;    // setup clocks of the repeated form
    logic [1:0] ndata;    // data cycles of a run or iteration
    logic       last_wr;  // last data cycle is a write
  } timing_t;
endpackage : lsdec_pkg

// >>> lsdec.sv
// decoder and timing sequencer for logic, test, invert and string instructions
//
// Contract
// - 001000dw plus addressing byte: AND, 2 clocks
// - 0010001w memory-to-register AND: 6 clocks, 1 cycle
// - group 100000w field 100: AND immediate 2/7
// - 0010010w plus data: accumulator AND, 2 clocks
// - 1000010w test, flags only, 2/5 clocks
// - 1111011w field 000: immediate test 2/5
// - 1010100w plus data: accumulator test, 2 clocks
// - 0000100w OR to memory: 7 clocks, read/write
// - group 100000w field 001: OR immediate 2/7
// - 0000110w plus data: accumulator OR, 2 clocks
// - XOR 001100dw and 0011010w, 2 clocks each
// - group 100000w field 110: XOR immediate 2/7
// - 1111011w field 010: invert, 2/6 clocks
// - 1010011w compare string: 10 clocks, 2 reads
// - 0110110w port input string: 9 clocks, 1 cycle
// - 1010110w load string: 5 clocks, 1 cycle
// - 1010010w move string: 7 clocks, read then write
// - 0110111w port output string: 8 clocks, 1 cycle
// - 1010111w scan string: one data cycle
// - 1010101w store string: 4 clocks, 1 cycle
// - repeat count from 16 or 32 bit count
// - prefixed compare: 5 + 9n, stop at mismatch
`timescale 1ns/100ps
module lsdec #(
  parameter int IMM_WIDE_BYTES = 4,  // bytes of a wide immediate
  parameter int SCAN_CLOCKS    = 7   // clocks of a single scan string
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,          // freezes all state while low
  input  wire logic [7:0]       byte_i,        // opcode stream byte
  input  wire logic             byte_valid_i,
  output logic                  byte_ready_o,
  input  wire logic [31:0]      count_i,       // count register contents
  input  wire logic             addr32_i,      // use 32-bit count form
  input  wire logic             match_i,       // datapath compare equal
  output lsdec_pkg::exec_t      exec_o,        // decoded instruction
  output logic                  busy_o,        // execution under way
  output logic                  bus_req_o,     // data cycle request
  output logic                  bus_write_o,   // data cycle is a write
  output logic                  done_o,        // last execution clock
  output logic                  bad_opcode_o,  // byte not of this group
  output logic [31:0]           count_o        // remaining repeat count
);

  // refuse parameter values the counters cannot serve
  if (IMM_WIDE_BYTES != 2 && IMM_WIDE_BYTES != 4)
  begin : g_bad_imm
    $error("immediate width must be 2 or 4 bytes");
  end
  if (SCAN_CLOCKS < 2 || SCAN_CLOCKS > 31)
  begin : g_bad_scan
    $error("scan clocks out of counter range");
  end

  typedef enum logic [2:0] {
    st_opcode, st_modrm, st_imm, st_issue, st_exec
  } state_t;

  state_t             state_reg;     // decode state
  lsdec_pkg::exec_t   exec_reg;      // decoded fields
  lsdec_pkg::timing_t tm_reg;        // latched timing
  lsdec_pkg::timing_t tm_next;       // timing of the decoded fields
  logic               grp_reg;       // opcode is a field-selected group
  logic               need_imm_reg;  // immediate follows
  logic               imm8_sx_reg;   // single sign-extended immediate byte
  logic [2:0]         imm_left_reg;  // immediate bytes still to come
  logic [1:0]         imm_idx_reg;   // next immediate byte lane
  logic [4:0]         phase_reg;     // clocks left in current phase
  logic               in_setup_reg;  // repeated-form setup phase
  logic [1:0]         data_left_reg; // data cycles left in phase
  logic [31:0]        count_reg;     // remaining iterations
  logic               stop_eq_reg;   // stop on mismatch
  logic               take;          // byte accepted this cycle
  logic               last_clk;      // last clock of current phase
  logic               finish;        // instruction ends this cycle
  logic [3:0]         cls;           // class bits of the offered byte

  // classify the first byte: returns {known, modrm, imm, group}
  function automatic logic [3:0] classify(input logic [7:0] b);
    logic [3:0] c;
    c = 4'h0;
    if (b[7:2] == lsdec_pkg::OPC_AND_RM || b[7:2] == lsdec_pkg::OPC_OR_RM ||
        b[7:2] == lsdec_pkg::OPC_XOR_RM || b[7:1] == lsdec_pkg::OPC_TEST_RM)
      c = 4'hC;
    else if (b[7:2] == lsdec_pkg::OPC_GRP_IMM)
      c = 4'hF;
    else if (b[7:1] == lsdec_pkg::OPC_GRP_UNA)
      c = 4'hF;
    else if (b[7:1] == lsdec_pkg::OPC_AND_ACC || b[7:1] == lsdec_pkg::OPC_OR_ACC ||
             b[7:1] == lsdec_pkg::OPC_XOR_ACC || b[7:1] == lsdec_pkg::OPC_TEST_ACC)
      c = 4'hA;
    else if (b[7:1] == lsdec_pkg::OPC_COMP || b[7:1] == lsdec_pkg::OPC_PIN ||
             b[7:1] == lsdec_pkg::OPC_LOAD || b[7:1] == lsdec_pkg::OPC_MOVE ||
             b[7:1] == lsdec_pkg::OPC_POUT || b[7:1] == lsdec_pkg::OPC_SCAN ||
             b[7:1] == lsdec_pkg::OPC_STOR)
      c = 4'h8;
    return c;
  endfunction : classify

  // operation named by a first byte outside the field-selected groups
  function automatic lsdec_pkg::op_t first_op(input logic [7:0] b);
    lsdec_pkg::op_t o;
    o = lsdec_pkg::op_and;
    if (b[7:2] == lsdec_pkg::OPC_OR_RM || b[7:1] == lsdec_pkg::OPC_OR_ACC)
      o = lsdec_pkg::op_or;
    else if (b[7:2] == lsdec_pkg::OPC_XOR_RM || b[7:1] == lsdec_pkg::OPC_XOR_ACC)
      o = lsdec_pkg::op_xor;
    else if (b[7:1] == lsdec_pkg::OPC_TEST_RM || b[7:1] == lsdec_pkg::OPC_TEST_ACC)
      o = lsdec_pkg::op_test;
    else if (b[7:1] == lsdec_pkg::OPC_COMP) o = lsdec_pkg::compare_string;
    else if (b[7:1] == lsdec_pkg::OPC_PIN) o = lsdec_pkg::port_input_string;
    else if (b[7:1] == lsdec_pkg::OPC_LOAD) o = lsdec_pkg::load_string;
    else if (b[7:1] == lsdec_pkg::OPC_MOVE) o = lsdec_pkg::move_string;
    else if (b[7:1] == lsdec_pkg::OPC_POUT) o = lsdec_pkg::port_output_string;
    else if (b[7:1] == lsdec_pkg::OPC_SCAN) o = lsdec_pkg::scan_string;
    else if (b[7:1] == lsdec_pkg::OPC_STOR) o = lsdec_pkg::store_string;
    return o;
  endfunction : first_op

  // build a timing record from its parts
  function automatic lsdec_pkg::timing_t mk(input int c, input int s,
                                            input int n, input logic w);
    lsdec_pkg::timing_t t;
    t.clocks  = 5'(c);
    t.setup   = 5'(s);
    t.ndata   = 2'(n);
    t.last_wr = w;
    return t;
  endfunction : mk

  // byte handshake: accepted only while decoding
  assign byte_ready_o = ce_i && (state_reg == st_opcode || state_reg == st_modrm ||
                                 state_reg == st_imm);
  assign take = byte_ready_o && byte_valid_i;
  assign cls  = classify(byte_i);

  // decode state sequence
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      state_reg <= st_opcode;
    else if (ce_i)
    begin
      case (state_reg)
        st_opcode:
          if (take && byte_i != lsdec_pkg::PFX_REPEAT && cls[3])
          begin
            if (cls[2]) state_reg <= st_modrm;
            else if (cls[1]) state_reg <= st_imm;
            else state_reg <= st_issue;
          end
        st_modrm:
          if (take)
          begin
            // group field must name one of this block's operations
            if (grp_reg && exec_reg.op == lsdec_pkg::op_not &&
                byte_i[5:3] != lsdec_pkg::FLD_NOT && byte_i[5:3] != lsdec_pkg::FLD_TEST)
              state_reg <= st_opcode;
            else if (grp_reg && exec_reg.op == lsdec_pkg::op_and &&
                     byte_i[5:3] != lsdec_pkg::FLD_AND && byte_i[5:3] != lsdec_pkg::FLD_OR &&
                     byte_i[5:3] != lsdec_pkg::FLD_XOR)
              state_reg <= st_opcode;
            else if (need_imm_reg && !(grp_reg && exec_reg.op == lsdec_pkg::op_not &&
                                      byte_i[5:3] == lsdec_pkg::FLD_NOT))
              state_reg <= st_imm;
            else
              state_reg <= st_issue;
          end
        st_imm:
          if (take && imm_left_reg == 3'h1)
            state_reg <= st_issue;
        st_issue:
          state_reg <= st_exec;
        st_exec:
          if (finish)
            state_reg <= st_opcode;
        default:
          state_reg <= st_opcode;
      endcase
    end
  end

  // bad opcode pulse, registered
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      bad_opcode_o <= 1'b0;
    else if (ce_i)
    begin
      bad_opcode_o <= 1'b0;
      if (state_reg == st_opcode && take && byte_i != lsdec_pkg::PFX_REPEAT &&
          !cls[3])
        bad_opcode_o <= 1'b1;
      else if (state_reg == st_modrm && take && grp_reg &&
               ((exec_reg.op == lsdec_pkg::op_not && byte_i[5:3] != lsdec_pkg::FLD_NOT &&
                 byte_i[5:3] != lsdec_pkg::FLD_TEST) ||
                (exec_reg.op == lsdec_pkg::op_and && byte_i[5:3] != lsdec_pkg::FLD_AND &&
                 byte_i[5:3] != lsdec_pkg::FLD_OR && byte_i[5:3] != lsdec_pkg::FLD_XOR)))
        bad_opcode_o <= 1'b1;
    end
  end

  // field capture from opcode, addressing and immediate bytes
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      exec_reg     <= '0;
      grp_reg      <= 1'b0;
      need_imm_reg <= 1'b0;
      imm8_sx_reg  <= 1'b0;
      imm_left_reg <= 3'h0;
      imm_idx_reg  <= 2'h0;
    end
    else if (ce_i)
    begin
      if (state_reg == st_opcode && take)
      begin
        if (byte_i == lsdec_pkg::PFX_REPEAT)
          exec_reg.repeated <= 1'b1;
        else
        begin
          exec_reg.op          <= first_op(byte_i);
          if (byte_i[7:1] == lsdec_pkg::OPC_GRP_UNA)
            exec_reg.op        <= lsdec_pkg::op_not;
          exec_reg.is_byte     <= !byte_i[0];
          // direction bit; forms without one write the addressed operand
          exec_reg.reg_dest    <= classify(byte_i) == 4'hC &&
                                  byte_i[7:1] != lsdec_pkg::OPC_TEST_RM &&
                                  byte_i[1];
          exec_reg.acc_form    <= classify(byte_i) == 4'hA;
          exec_reg.mem_operand <= classify(byte_i) == 4'h8;
          // only string forms keep the repeat prefix
          if (classify(byte_i) != 4'h8)
            exec_reg.repeated  <= 1'b0;
          exec_reg.imm         <= 32'h0;
          grp_reg      <= byte_i[7:2] == lsdec_pkg::OPC_GRP_IMM ||
                          byte_i[7:1] == lsdec_pkg::OPC_GRP_UNA;
          need_imm_reg <= cls[1];
          imm8_sx_reg  <= byte_i[7:2] == lsdec_pkg::OPC_GRP_IMM && byte_i[1];
          imm_left_reg <= (byte_i[0] && !(byte_i[7:2] == lsdec_pkg::OPC_GRP_IMM &&
                           byte_i[1])) ? 3'(IMM_WIDE_BYTES) : 3'h1;
          imm_idx_reg  <= 2'h0;
        end
      end
      else if (state_reg == st_modrm && take)
      begin
        exec_reg.mod_field   <= byte_i[7:6];
        exec_reg.reg_field   <= byte_i[5:3];
        exec_reg.rm_field    <= byte_i[2:0];
        exec_reg.mem_operand <= byte_i[7:6] != lsdec_pkg::MOD_REG;
        if (grp_reg && exec_reg.op == lsdec_pkg::op_not &&
            byte_i[5:3] == lsdec_pkg::FLD_TEST)
          exec_reg.op <= lsdec_pkg::op_test;
        else if (grp_reg && exec_reg.op == lsdec_pkg::op_and)
        begin
          if (byte_i[5:3] == lsdec_pkg::FLD_OR)
            exec_reg.op <= lsdec_pkg::op_or;
          else if (byte_i[5:3] == lsdec_pkg::FLD_XOR)
            exec_reg.op <= lsdec_pkg::op_xor;
          else
            exec_reg.op <= lsdec_pkg::op_and;
        end
      end
      else if (state_reg == st_imm && take)
      begin
        // little-endian immediate, single signed byte widened
        if (imm8_sx_reg)
          exec_reg.imm <= {{24{byte_i[7]}}, byte_i};
        else
          exec_reg.imm[8*imm_idx_reg +: 8] <= byte_i;
        imm_idx_reg  <= imm_idx_reg + 2'h1;
        imm_left_reg <= imm_left_reg - 3'h1;
      end
      else if (finish)
        exec_reg.repeated <= 1'b0;
    end
  end

  // clock and data cycle counts of the decoded instruction
  always_comb
  begin
    tm_next = mk(lsdec_pkg::REG_CLOCKS, 0, 0, 1'b0);
    case (exec_reg.op)
      lsdec_pkg::compare_string:
        tm_next = mk(exec_reg.repeated ? lsdec_pkg::R_COMP_IT : lsdec_pkg::COMP_CLK,
                     lsdec_pkg::R_COMP_SET, 2, 1'b0);
      lsdec_pkg::port_input_string:
        tm_next = mk(exec_reg.repeated ? lsdec_pkg::R_PIN_IT : lsdec_pkg::PIN_CLK,
                     lsdec_pkg::R_PIN_SET, 1, 1'b1);
      lsdec_pkg::load_string:
        tm_next = mk(exec_reg.repeated ? lsdec_pkg::R_LOAD_IT : lsdec_pkg::LOAD_CLK,
                     lsdec_pkg::R_LOAD_SET, 1, 1'b0);
      lsdec_pkg::move_string:
        tm_next = mk(exec_reg.repeated ? lsdec_pkg::R_MOVE_IT : lsdec_pkg::MOVE_CLK,
                     lsdec_pkg::R_MOVE_SET, 2, 1'b1);
      lsdec_pkg::port_output_string:
        tm_next = mk(exec_reg.repeated ? lsdec_pkg::R_POUT_IT : lsdec_pkg::POUT_CLK,
                     lsdec_pkg::R_POUT_SET, 1, 1'b0);
      lsdec_pkg::scan_string:
        tm_next = mk(exec_reg.repeated ? lsdec_pkg::R_SCAN_IT : SCAN_CLOCKS,
                     lsdec_pkg::R_SCAN_SET, 1, 1'b0);
      lsdec_pkg::store_string:
        tm_next = mk(exec_reg.repeated ? lsdec_pkg::R_STOR_IT : lsdec_pkg::STOR_CLK,
                     lsdec_pkg::R_STOR_SET, 1, 1'b1);
      default:
        if (exec_reg.mem_operand)
        begin
          if (exec_reg.op == lsdec_pkg::op_test)
            tm_next = mk(lsdec_pkg::TEST_MEM_CLK, 0, 1, 1'b0);
          else if (exec_reg.op == lsdec_pkg::op_not)
            tm_next = mk(lsdec_pkg::NOT_MEM_CLK, 0, 2, 1'b1);
          else if (exec_reg.reg_dest)
            tm_next = mk(lsdec_pkg::MEM_RD_CLK, 0, 1, 1'b0);
          else
            tm_next = mk(lsdec_pkg::MEM_RMW_CLK, 0, 2, 1'b1);
        end
    endcase
  end

  // execution sequencer: phases, data cycles and repeat count
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      tm_reg        <= '0;
      phase_reg     <= 5'h0;
      in_setup_reg  <= 1'b0;
      data_left_reg <= 2'h0;
      count_reg     <= 32'h0;
      stop_eq_reg   <= 1'b0;
    end
    else if (ce_i)
    begin
      if (state_reg == st_issue)
      begin
        tm_reg       <= tm_next;
        in_setup_reg <= exec_reg.repeated;
        phase_reg    <= exec_reg.repeated ? tm_next.setup : tm_next.clocks;
        data_left_reg <= exec_reg.repeated ? 2'h0 : tm_next.ndata;
        // count register in its 16 or 32 bit form
        count_reg    <= addr32_i ? count_i : {16'h0000, count_i[15:0]};
        stop_eq_reg  <= exec_reg.repeated &&
                        (exec_reg.op == lsdec_pkg::compare_string ||
                         exec_reg.op == lsdec_pkg::scan_string);
      end
      else if (state_reg == st_exec)
      begin
        if (data_left_reg != 2'h0)
          data_left_reg <= data_left_reg - 2'h1;
        if (!last_clk)
          phase_reg <= phase_reg - 5'h1;
        else if (!finish)
        begin
          // start the next iteration
          phase_reg     <= tm_reg.clocks;
          data_left_reg <= tm_reg.ndata;
          in_setup_reg  <= 1'b0;
          if (!in_setup_reg)
            count_reg <= count_reg - 32'h1;
        end
        else if (!in_setup_reg && tm_reg.setup != 5'h0 && count_reg != 32'h0)
          count_reg <= count_reg - 32'h1;
      end
    end
  end

  // phase end and instruction end
  assign last_clk = state_reg == st_exec && phase_reg == 5'h1;
  always_comb
  begin
    finish = 1'b0;
    if (last_clk)
    begin
      if (!exec_reg.repeated)
        finish = 1'b1;
      else if (in_setup_reg)
        finish = count_reg == 32'h0;
      else
        finish = count_reg == 32'h1 || (stop_eq_reg && !match_i);
    end
  end

  // data cycles come first in each phase, a write only as the last
  assign bus_req_o   = ce_i && state_reg == st_exec && data_left_reg != 2'h0;
  assign bus_write_o = bus_req_o && tm_reg.last_wr && data_left_reg == 2'h1;
  assign done_o      = ce_i && finish;
  assign busy_o      = state_reg == st_issue || state_reg == st_exec;
  assign exec_o      = exec_reg;
  assign count_o     = count_reg;

endmodule : lsdec

// >>> fetch_model.sv
// instruction prefetch model that offers opcode bytes to the decoder
`timescale 1ns/100ps
module fetch_model (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       ready_i,          // decoder can take a byte
  output logic [7:0]      byte_o = 8'h00,
  output logic            valid_o = 1'b0
);
  logic [7:0] q[$];                         // bytes not yet taken
  logic [1:0] pace_reg = 2'h0;              // stalls new offers one clock in four

  // bench appends the next byte of the stream
  task push(input logic [7:0] b);
    q.push_back(b);
  endtask : push

  // an offer holds until taken; an idle line shows the inverse of its last value
  always @(posedge clk_i)
  begin
    pace_reg <= pace_reg + 2'h1;
    if (valid_o && ready_i && !srst_i)
      void'(q.pop_front());
    if (srst_i || (valid_o && ready_i) || !valid_o)
    begin
      // taken byte is gone: offer the queue head unless this is a stall cycle
      if (!srst_i && q.size() > 0 && pace_reg != 2'h3)
      begin
        valid_o <= 1'b1;
        byte_o  <= q[0];
      end
      else
      begin
        valid_o <= 1'b0;
        byte_o  <= ~byte_o;
      end
    end
  end
endmodule : fetch_model

// >>> lsdec_properties.sv
// concurrent checks on the decoder ports
`timescale 1ns/100ps
module lsdec_properties (
  input wire logic             clk_i,
  input wire logic             srst_i,
  input wire logic [31:0]      count_i,
  input wire logic             addr32_i,
  input wire lsdec_pkg::exec_t exec_o,
  input wire logic             byte_ready_o,
  input wire logic             busy_o,
  input wire logic             bus_req_o,
  input wire logic             bus_write_o,
  input wire logic             done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // a data read followed at once by a data write
  sequence s_read_write;
    bus_req_o && !bus_write_o ##1 bus_req_o && bus_write_o;
  endsequence
  // nine quiet clocks after the issue cycle, then completion
  sequence s_ten_clocks;
    !done_o [*8] ##1 !done_o [*2] ##1 done_o;
  endsequence
  property p_reg_time;
    $rose(busy_o) && !exec_o.mem_operand |-> !done_o [*2] ##1 done_o;
  endproperty
  property p_rmw_time;
    $rose(busy_o) && exec_o.mem_operand && !exec_o.reg_dest
      && exec_o.op < lsdec_pkg::op_test |-> !done_o [*7] ##1 done_o;
  endproperty
  property p_or_bus;
    $rose(busy_o) && exec_o.mem_operand && !exec_o.reg_dest
      && exec_o.op == lsdec_pkg::op_or |=> s_read_write;
  endproperty
  property p_comp_time;
    $rose(busy_o) && exec_o.op == lsdec_pkg::compare_string && !exec_o.repeated
      |-> s_ten_clocks;
  endproperty
  property p_rep_zero;
    $rose(busy_o) && exec_o.repeated && exec_o.op == lsdec_pkg::compare_string
      && (addr32_i ? count_i : {16'h0000, count_i[15:0]}) == 32'h0
      |-> !done_o [*5] ##1 done_o;
  endproperty
  property p_stor_time;
    $rose(busy_o) && exec_o.op == lsdec_pkg::store_string && !exec_o.repeated
      |=> !done_o [*3] ##1 done_o;
  endproperty
  property p_busy_ready;
    busy_o |-> !byte_ready_o;
  endproperty
  property p_write_qual;
    bus_write_o |-> bus_req_o && busy_o;
  endproperty
  a_reg_time: assert property (p_reg_time) else $error("register form length wrong");
  a_rmw_time: assert property (p_rmw_time) else $error("memory update length wrong");
  a_or_bus: assert property (p_or_bus) else $error("or to memory bus order wrong");
  a_comp_time: assert property (p_comp_time) else $error("compare length wrong");
  a_rep_zero: assert property (p_rep_zero) else $error("zero count not setup only");
  a_stor_time: assert property (p_stor_time) else $error("store length wrong");
  a_busy_ready: assert property (p_busy_ready) else $error("byte taken while busy");
  a_write_qual: assert property (p_write_qual) else $error("write outside data cycle");
endmodule : lsdec_properties

bind lsdec lsdec_properties u_props (.clk_i, .srst_i, .count_i, .addr32_i, .exec_o,
  .byte_ready_o, .busy_o, .bus_req_o, .bus_write_o, .done_o);

// >>> lsdec_tb.sv
// self-checking bench for the logic and string instruction decoder
`timescale 1ns/100ps
module lsdec_tb;
  logic             clk_i = 1'b0;
  logic             srst_i = 1'b1;
  logic [31:0]      count_i = 32'h0;
  logic             addr32_i = 1'b0;
  logic             match_i = 1'b1;
  logic [7:0]       byte_i;
  logic             byte_valid_i;
  logic             byte_ready_o;
  lsdec_pkg::exec_t exec_o;
  logic             busy_o;
  logic             bus_req_o;
  logic             bus_write_o;
  logic             done_o;
  logic             bad_opcode_o;
  logic [31:0]      count_o;
  logic [15:0]      exp_q[$];          // op, clocks, data cycles
  logic [31:0]      rnd = 32'h443AAB88;
  int               bad_count = 0;
  int               num_checks = 0;
  int               cyc = 0;           // busy clocks of the running op
  int               reqs = 0;          // data cycles of the running op
  always #20 clk_i = ~clk_i;
  lsdec #(.IMM_WIDE_BYTES(4), .SCAN_CLOCKS(7)) uut (.clk_i, .srst_i, .ce_i(1'b1), .byte_i,
    .byte_valid_i, .byte_ready_o, .count_i, .addr32_i, .match_i, .exec_o, .busy_o,
    .bus_req_o, .bus_write_o, .done_o, .bad_opcode_o, .count_o);
  fetch_model fm (.clk_i, .srst_i, .ready_i(byte_ready_o), .byte_o(byte_i),
    .valid_o(byte_valid_i));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task chk(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  task end_sim;
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // op numbers follow op_t order; n below zero means a refused byte
  task run(input int nb, input logic [47:0] b, input int op, input int n, input int r);
    int k;
    exp_q.push_back(n < 0 ? 16'hFFFF : {4'(op), 8'(n), 4'(r)});
    for (k = nb - 1; k >= 0; k--) fm.push(b[8*k +: 8]);
    for (k = 0; k < 400 && exp_q.size() != 0; k++) @(posedge clk_i);
    if (k == 400)
    begin
      bad_count++;
      end_sim();
    end
    @(posedge clk_i);
  endtask : run
  task setc(input logic [31:0] c, input logic a, input logic m);
    count_i  <= c;
    addr32_i <= a;
    match_i  <= m;
  endtask : setc
  // measures each finished op and compares it with the oldest note
  always @(posedge clk_i)
  begin
    if (!srst_i)
    begin
      cyc = busy_o ? cyc + 1 : cyc;
      reqs = bus_req_o ? reqs + 1 : reqs;
      if (done_o || bad_opcode_o)
      begin
        if (exp_q.size() == 0)
          chk(32'h1, 32'h0);
        else
          chk({16'h0, done_o ? {exec_o.op, 8'(cyc - 1), 4'(reqs)} : 16'hFFFF}, {16'h0, exp_q.pop_front()});
        cyc = 0;
        reqs = 0;
      end
    end
  end
  initial
  begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    chk({count_o[30:0], byte_ready_o}, 32'h1);
    run(2, 48'h21C8, 0, 2, 0);
    chk({exec_o.is_byte, exec_o.reg_dest}, 32'h0);
    run(2, 48'h22C1, 0, 2, 0);
    chk({exec_o.is_byte, exec_o.reg_dest}, 32'h3);
    run(3, 48'hF321C8, 0, 2, 0);
    run(2, 48'h2300, 0, 6, 1);
    run(3, 48'h80E155, 0, 2, 0);
    run(6, 48'h812011223344, 0, 7, 2);
    chk(exec_o.imm, 32'h44332211);
    run(2, 48'h245A, 0, 2, 0);
    run(2, 48'h8500, 3, 5, 1);
    run(2, 48'h84C0, 3, 2, 0);
    run(3, 48'hF6C37E, 3, 2, 0);
    run(6, 48'hF70001020304, 3, 5, 1);
    run(2, 48'hA833, 3, 2, 0);
    run(2, 48'h0900, 1, 7, 2);
    run(3, 48'h83C8F0, 1, 2, 0);
    chk(exec_o.imm, 32'hFFFFFFF0);
    run(5, 48'h0D01020304, 1, 2, 0);
    run(2, 48'h31C0, 2, 2, 0);
    run(2, 48'h3411, 2, 2, 0);
    run(3, 48'h803044, 2, 7, 2);
    run(2, 48'hF6D0, 4, 2, 0);
    run(2, 48'hF710, 4, 6, 2);
    run(2, 48'hF6F8, 0, -1, 0);
    run(1, 48'hF2, 0, -1, 0);
    run(1, 48'hA6, 5, 10, 2);
    run(1, 48'h6C, 6, 9, 1);
    run(1, 48'hAC, 7, 5, 1);
    run(1, 48'hA4, 8, 7, 2);
    run(1, 48'h6E, 9, 8, 1);
    run(1, 48'hAE, 10, 7, 1);
    run(1, 48'hAA, 11, 4, 1);
    setc(32'h00010002, 1'b0, 1'b0);
    run(2, 48'hF3A7, 5, 14, 2);
    chk(count_o, 32'h1);
    setc(32'h00000002, 1'b0, 1'b1);
    run(2, 48'hF3A7, 5, 23, 4);
    setc(32'h00010000, 1'b0, 1'b1);
    run(2, 48'hF3A7, 5, 5, 0);
    setc(32'h00000003, 1'b1, 1'b1);
    run(2, 48'hF3AA, 11, 20, 3);
    repeat (3)
    begin
      rnd = lfsr(rnd);
      setc({rnd[31:16], 14'h0, rnd[1:0]}, 1'b0, 1'b1);
      run(2, 48'hF3AC, 7, 5 + 6 * int'(rnd[1:0]), int'(rnd[1:0]));
    end
    end_sim();
  end
endmodule : lsdec_tb
